// ==== logic/mbt_base_timer.v ====
// four-group base timer with capture/compare channel registers
// assumes an axi4-lite master on clk, encoder and ext irq pins asynchronous,
// tb0_irq_pulse a one-cycle pulse from logic on clk
//
// What this block does
// - four groups, 16-bit counter, eight channel registers
// - each channel picks measurement or waveform function
// - clock or encoder source divided by 2(n+1), undivided when n is 31
// - timer event source divided by 2(m+1)
// - run bit counts; cleared holds counter in reset
// - reset on match, low pin, bit overflow
// - ext reset pin chosen once for all even groups and once for all odd groups
// - match reset two counting ticks after match
// - paired groups reset each other
// - overflow flag from bit 9, 14 or 15
// - counter read returns live count
// - counter write loads while running, else ignored
// - up/down mode turns at FFFFh and 0000h
// - up/down with match turns down two counts later
// - two-phase mode counts all encoder edges
// - two-phase counting down skips match reset
`include "mbt_consts.vh"

module mbt_base_timer (
  // clock and reset
  input wire clk,
  input wire resetn,
  // axi4-lite write address and data
  input wire [8:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [8:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // count source event from the neighbouring timer
  input wire tb0_irq_pulse,
  // encoder phases, groups 0 and 1
  input wire [1:0] encoder_phase_a,
  input wire [1:0] encoder_phase_b,
  // external interrupt pins, low level resets
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  // status toward the system
  output wire [3:0] counter_overflow_flag,
  output wire [31:0] chan_wave_drive
);

  // write channel capture
  reg aw_have_r;
  reg w_have_r;
  reg [8:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire wr_fire;
  wire wr_ok;
  wire [1:0] wr_grp;
  wire [3:0] wr_idx;
  reg [7:0] pinsel_r;
  reg [15:0] chan_r [0:31];
  reg [31:0] rd_val;
  reg rd_ok;
  wire [1:0] rd_grp;
  wire [3:0] rd_idx;
  wire [31:0] wmask;
  wire [31:0] wnew;
  integer i;

  // per-group state exposed for the read mux
  wire [35:0] ctla_v;
  wire [27:0] ctlb_v;
  wire [27:0] oc0_v;
  wire [63:0] chsel_v;
  wire [63:0] cnt_v;
  wire [3:0] down_v;
  wire [3:0] rst_evt;

  // synchronisers for pins
  reg [1:0] ea_s1_r;
  reg [1:0] ea_s2_r;
  reg [1:0] ea_p_r;
  reg [1:0] eb_s1_r;
  reg [1:0] eb_s2_r;
  reg [1:0] eb_p_r;
  reg [1:0] xp_s1_r;
  reg [1:0] xp_s2_r;

  // byte strobes widened to a bit mask; each register merges only its own lanes
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wnew = w_data_r & wmask;

  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready = ~w_have_r;
  assign s_axi_arready = ~s_axi_rvalid;
  // write waits until the previous response has been taken
  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_grp = aw_addr_r[7:6];
  assign wr_idx = aw_addr_r[5:2];
  assign wr_ok = (aw_addr_r == `MBT_ADDR_PINSEL) |
    (~aw_addr_r[8] & (wr_idx[`MBT_IDX_CHAN_BIT] | (wr_idx <= `MBT_IDX_STAT)));
  assign rd_grp = s_axi_araddr[7:6];
  assign rd_idx = s_axi_araddr[5:2];

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 9'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MBT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_r)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && !w_have_r)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_r <= 1'b0;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // pin selection and channel registers (global array)
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinsel_r <= 8'h00;
      for (i = 0; i < 32; i = i + 1)
        chan_r[i] <= 16'h0000;
    end
    else if (wr_fire)
    begin
      if (aw_addr_r == `MBT_ADDR_PINSEL)
        pinsel_r <= ((pinsel_r & ~wmask[7:0]) | wnew[7:0]) & 8'hcc;
      if (!aw_addr_r[8] && wr_idx[`MBT_IDX_CHAN_BIT])
        chan_r[{wr_grp, wr_idx[2:0]}] <=
          (chan_r[{wr_grp, wr_idx[2:0]}] & ~wmask[15:0]) | wnew[15:0];
    end
  end

  // read mux, answer registered one cycle after the address is taken
  always @*
  begin
    rd_val = 32'h0000_0000;
    rd_ok = ~s_axi_araddr[8];
    if (s_axi_araddr == `MBT_ADDR_PINSEL)
    begin
      rd_val = {24'h0, pinsel_r};
      rd_ok = 1'b1;
    end
    else if (!s_axi_araddr[8])
    begin
      if (rd_idx[`MBT_IDX_CHAN_BIT])
        rd_val = {16'h0, chan_r[{rd_grp, rd_idx[2:0]}]};
      else
        case (rd_idx)
          `MBT_IDX_CTLA: rd_val = {23'h0, ctla_v[rd_grp*9 +: 9]};
          `MBT_IDX_CTLB: rd_val = {25'h0, ctlb_v[rd_grp*7 +: 7]};
          `MBT_IDX_CNT: rd_val = {16'h0, cnt_v[rd_grp*16 +: 16]};
          `MBT_IDX_OC0: rd_val = {25'h0, oc0_v[rd_grp*7 +: 7]};
          `MBT_IDX_CHSEL: rd_val = {16'h0, chsel_v[rd_grp*16 +: 16]};
          `MBT_IDX_STAT: rd_val = {30'h0, down_v[rd_grp], counter_overflow_flag[rd_grp]};
          default: rd_ok = 1'b0;
        endcase
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MBT_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_val : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // pins pass two flops; a third stage on the encoder phases keeps history for edge detection
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ea_s1_r <= 2'b00;
      ea_s2_r <= 2'b00;
      ea_p_r <= 2'b00;
      eb_s1_r <= 2'b00;
      eb_s2_r <= 2'b00;
      eb_p_r <= 2'b00;
      xp_s1_r <= 2'b11;
      xp_s2_r <= 2'b11;
    end
    else
    begin
      ea_s1_r <= encoder_phase_a;
      ea_s2_r <= ea_s1_r;
      ea_p_r <= ea_s2_r;
      eb_s1_r <= encoder_phase_b;
      eb_s2_r <= eb_s1_r;
      eb_p_r <= eb_s2_r;
      xp_s1_r <= {ext_irq_pin_b, ext_irq_pin_a};
      xp_s2_r <= xp_s1_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : grp
      reg [8:0] ctla_r;
      reg [6:0] ctlb_r;
      reg [6:0] oc0_r;
      reg [15:0] chsel_r;
      reg [15:0] cnt_r;
      reg [5:0] pre_r;
      reg stage_r;
      reg down_r;
      reg flag_r;
      wire wr_here = wr_fire & ~aw_addr_r[8] & (wr_grp == g);
      wire [1:0] src = ctla_r[`MBT_SRC_LSB +: 2];
      wire [4:0] div = ctla_r[`MBT_DIV_LSB +: 5];
      wire [1:0] itsel = ctla_r[`MBT_IT_LSB +: 2];
      wire [2:0] rt = ctlb_r[`MBT_RT_LSB +: 3];
      wire run = ctlb_r[`MBT_RUN_BIT];
      // up/down and two-phase exist only in groups 0 and 1
      wire [1:0] mode = (g < 2) ? ctlb_r[`MBT_MODE_LSB +: 2] : `MBT_MODE_INC;
      wire [1:0] ps = (g % 2 == 0) ? pinsel_r[`MBT_PS_EVEN_LSB +: 2]
                                   : pinsel_r[`MBT_PS_ODD_LSB +: 2];
      wire pin_low = (ps == `MBT_PS_PIN_A & ~xp_s2_r[0]) |
                     (ps == `MBT_PS_PIN_B & ~xp_s2_r[1]);
      wire enc_edge;
      wire enc_up;
      wire ev;
      wire nodiv;
      wire wrap;
      wire tick;
      wire up;
      wire [15:0] step;
      wire match_en = (rt == `MBT_RT_MATCH);
      wire ext_en = (rt == `MBT_RT_EXT) | (oc0_r[`MBT_ALT_BIT] & match_en);
      wire match_due = tick & stage_r & match_en;
      wire match_rst;
      wire ovf_rst;
      wire ovf_evt;
      wire pair_rst;
      if (g < 2)
      begin : enc
        // quadrature: every edge counts, direction from phase order
        assign enc_edge = (ea_s2_r[g] ^ ea_p_r[g]) | (eb_s2_r[g] ^ eb_p_r[g]);
        assign enc_up = ea_s2_r[g] ^ eb_p_r[g];
      end
      else
      begin : noenc
        assign enc_edge = 1'b0;
        assign enc_up = 1'b1;
      end
      assign ev = (src == `MBT_SRC_F1) | (src == `MBT_SRC_TB0 & tb0_irq_pulse) |
                  (src == `MBT_SRC_ENC & enc_edge);
      // timer event source has no bypass code; 31 then divides by 64
      assign nodiv = (src != `MBT_SRC_TB0) & (div == `MBT_DIV_NONE);
      assign wrap = (pre_r == {div, 1'b1});
      assign tick = run & ev & (nodiv | wrap);
      assign up = (mode == `MBT_MODE_UPDN) ? ~down_r :
                  (mode == `MBT_MODE_ENC) ? enc_up : 1'b1;
      assign step = up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
      assign match_rst = match_due & (mode == `MBT_MODE_INC |
                         (mode == `MBT_MODE_ENC & enc_up));
      assign ovf_rst = tick & up & ((rt == `MBT_RT_OVF15 & cnt_r == 16'hffff) |
                       (rt == `MBT_RT_OVF9 & cnt_r[9:0] == 10'h3ff));
      assign rst_evt[g] = run & ((ext_en & pin_low) | match_rst | ovf_rst);
      assign pair_rst = rst_evt[g] | rst_evt[g ^ 1];
      assign ovf_evt = tick & up & ((itsel == `MBT_IT_B15 & cnt_r == 16'hffff) |
                       (itsel == `MBT_IT_B14 & cnt_r[14:0] == 15'h7fff) |
                       (itsel == `MBT_IT_B9 & cnt_r[9:0] == 10'h3ff));

      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          ctla_r <= 9'h000;
          ctlb_r <= 7'h00;
          oc0_r <= 7'h00;
          chsel_r <= 16'h0000;
          flag_r <= 1'b0;
        end
        else
        begin
          if (wr_here && wr_idx == `MBT_IDX_CTLA)
            ctla_r <= (ctla_r & ~wmask[8:0]) | wnew[8:0];
          if (wr_here && wr_idx == `MBT_IDX_CTLB)
            ctlb_r <= (ctlb_r & ~wmask[6:0]) | wnew[6:0];
          if (wr_here && wr_idx == `MBT_IDX_OC0)
            oc0_r <= ((oc0_r & ~wmask[6:0]) | wnew[6:0]) & 7'h47;
          if (wr_here && wr_idx == `MBT_IDX_CHSEL)
            chsel_r <= (chsel_r & ~wmask[15:0]) | wnew[15:0];
          // a new overflow wins over a write-one clear in the same cycle
          if (ovf_evt)
            flag_r <= 1'b1;
          else if (wr_here && wr_idx == `MBT_IDX_STAT && w_strb_r[0] && w_data_r[0])
            flag_r <= 1'b0;
        end
      end

      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          cnt_r <= `MBT_CNT_RST;
          pre_r <= 6'h00;
          stage_r <= 1'b0;
          down_r <= 1'b0;
        end
        else if (!run)
        begin
          // stopped means held in reset
          cnt_r <= `MBT_CNT_RST;
          pre_r <= 6'h00;
          stage_r <= 1'b0;
          down_r <= 1'b0;
        end
        else
        begin
          if (ev)
            pre_r <= (nodiv | wrap) ? 6'h00 : pre_r + 6'h01;
          if (wr_here && wr_idx == `MBT_IDX_CNT)
            cnt_r <= (cnt_r & ~wmask[15:0]) | wnew[15:0];
          else if (pair_rst)
            cnt_r <= `MBT_CNT_RST;
          else if (tick)
            cnt_r <= step;
          // armed on the tick that leaves ch0; the next tick resets, period ch0+2
          if (pair_rst)
            stage_r <= 1'b0;
          else if (tick)
            stage_r <= match_en & up & (cnt_r == chan_r[g*8]);
          if (pair_rst || mode != `MBT_MODE_UPDN)
            down_r <= 1'b0;
          else if (tick)
          begin
            // turning on the step that lands on FFFFh, so FFFFh is still shown
            if (match_due || (up && cnt_r == 16'hfffe))
              down_r <= 1'b1;
            else if (!up && cnt_r == 16'h0001)
              down_r <= 1'b0;
          end
        end
      end

      assign ctla_v[g*9 +: 9] = ctla_r;
      assign ctlb_v[g*7 +: 7] = ctlb_r;
      assign oc0_v[g*7 +: 7] = oc0_r;
      assign chsel_v[g*16 +: 16] = chsel_r;
      assign cnt_v[g*16 +: 16] = cnt_r;
      assign down_v[g] = down_r;
      assign counter_overflow_flag[g] = flag_r;
      // enabled channel in waveform function drives its shared pin
      assign chan_wave_drive[g*8 +: 8] = chsel_r[15:8] & ~chsel_r[7:0];
    end
  endgenerate

endmodule

// ==== logic/mbt_consts.vh ====
// constants for the multifunction i/o base timer
// assumes a 32-bit axi4-lite register slave with 9-bit byte addresses
`ifndef MBT_CONSTS_VH
`define MBT_CONSTS_VH

// register index within a group, byte address = {group, index, 2'b00}
`define MBT_IDX_CTLA 4'h0
`define MBT_IDX_CTLB 4'h1
`define MBT_IDX_CNT 4'h2
`define MBT_IDX_OC0 4'h3
`define MBT_IDX_CHSEL 4'h4
`define MBT_IDX_STAT 4'h5
`define MBT_IDX_CHAN_BIT 3
`define MBT_ADDR_PINSEL 9'h100

// counter_control_a fields
`define MBT_SRC_LSB 0
`define MBT_DIV_LSB 2
`define MBT_IT_LSB 7
// counter_control_b fields
`define MBT_RT_LSB 0
`define MBT_RUN_BIT 4
`define MBT_MODE_LSB 5
// channel0_output_control fields
`define MBT_WMODE_LSB 0
`define MBT_ALT_BIT 6
// ext_pin_select_reg fields
`define MBT_PS_EVEN_LSB 2
`define MBT_PS_ODD_LSB 6

// count source codes
`define MBT_SRC_TB0 2'b01
`define MBT_SRC_ENC 2'b10
`define MBT_SRC_F1 2'b11
`define MBT_DIV_NONE 5'h1f

// reset timing codes
`define MBT_RT_OVF15 3'b001
`define MBT_RT_MATCH 3'b010
`define MBT_RT_OVF9 3'b011
`define MBT_RT_EXT 3'b100

// count modes
`define MBT_MODE_INC 2'b00
`define MBT_MODE_UPDN 2'b01
`define MBT_MODE_ENC 2'b10

// overflow interrupt select
`define MBT_IT_B15 2'b00
`define MBT_IT_B14 2'b01
`define MBT_IT_B9 2'b10

// pin select codes
`define MBT_PS_PIN_A 2'b01
`define MBT_PS_PIN_B 2'b10

`define MBT_CNT_RST 16'h0000
`define MBT_RESP_OKAY 2'b00
`define MBT_RESP_SLVERR 2'b10

`endif

// ==== tb/mbt_checker.sv ====
// assertions on the base timer's bus handshakes and status outputs
// assumes it is bound into every base timer instance, one clock domain
module mbt_checker (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // status
  input wire [3:0] counter_overflow_flag,
  input wire [31:0] chan_wave_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_bresp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
  a_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
  a_read_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_read_once:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answered twice");
  a_flag_sticky:
    assert property (|(~counter_overflow_flag & $past(counter_overflow_flag))
      |-> ##[0:1] s_axi_bvalid) else $error("flag cleared without write");
  a_wave_from_reg:
    assert property ($changed(chan_wave_drive) |-> ##[0:1] s_axi_bvalid)
      else $error("wave drive changed without write");
endmodule

bind mbt_base_timer mbt_checker mbt_checker_inst (.clk(clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .counter_overflow_flag(counter_overflow_flag), .chan_wave_drive(chan_wave_drive));

// ==== tb/mbt_quad_model.sv ====
// two-phase encoder and external reset pins beyond the timer
// assumes callers on clk; pins idle high as with a pull-up
module mbt_quad_model (
  // clock
  input wire logic clk,
  // encoder phases, groups 0 and 1
  output logic [1:0] phase_a,
  output logic [1:0] phase_b,
  // external interrupt pins
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] s0 = 2'd0;
  logic [1:0] s1 = 2'd0;
  // gray walk, a rises before b when counting up
  assign phase_a = {s1[1] ^ s1[0], s0[1] ^ s0[0]};
  assign phase_b = {s1[1], s0[1]};
  initial {pin_a, pin_b} = 2'b11;
  // four clocks per edge so the timer's synchroniser sees each one
  task automatic move(input int g, input int n, input bit up);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      if (g == 0)
        s0 <= up ? s0 + 2'd1 : s0 - 2'd1;
      else
        s1 <= up ? s1 + 2'd1 : s1 - 2'd1;
    end
    // let the last edge pass the timer's synchroniser before anyone reads
    repeat (4) @(posedge clk);
  endtask
  task automatic pins(input bit a, input bit b);
    pin_a <= a;
    pin_b <= b;
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the four-group base timer
// assumes the encoder model owns phases and pins, bus tasks own axi inputs
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [8:0] awaddr = 9'h000;
  logic [8:0] araddr = 9'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, tb0 = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ia, ib;
  logic [1:0] bresp, rresp, rr, wb, pa, pb;
  logic [31:0] rdata, wave, v, c;
  logic [3:0] flag;
  int err_total = 0;
  int total_checks = 0;
  int g, i, n, ev;
  always #2 clk = ~clk;
  mbt_base_timer mbt_base_timer_inst (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tb0_irq_pulse(tb0),
    .encoder_phase_a(pa), .encoder_phase_b(pb), .ext_irq_pin_a(ia), .ext_irq_pin_b(ib),
    .counter_overflow_flag(flag), .chan_wave_drive(wave));
  mbt_quad_model mbt_quad_model_inst (.clk(clk), .phase_a(pa), .phase_b(pb), .pin_a(ia),
    .pin_b(ib));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    complete_run();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ready raised after a random stall to exercise the slave's holding;
  // handshakes are judged at the falling edge, where every signal has settled
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    int k;
    int dly;
    bit aw_go, w_go, b_go;
    k = 0;
    dly = $urandom % 3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (dly == 0);
    do
    begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid && bready;
      wb = bresp;
      @(posedge clk);
      k++;
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      if (k >= dly && !b_go) bready <= 1'b1;
    end while (!b_go && k < 64);
    bready <= 1'b0;
    if (k >= 64) hang();
    @(posedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    int k;
    int dly;
    bit ar_go, r_go;
    k = 0;
    dly = $urandom % 3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dly == 0);
    do
    begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid && rready;
      d = rdata;
      rr = rresp;
      @(posedge clk);
      k++;
      if (ar_go) arvalid <= 1'b0;
      if (k >= dly && !r_go) rready <= 1'b1;
    end while (!r_go && k < 64);
    rready <= 1'b0;
    if (k >= 64) hang();
    @(posedge clk);
  endtask
  task automatic pulse(input int cnt);
    repeat (cnt)
    begin
      tb0 <= 1'b1;
      @(posedge clk);
      tb0 <= 1'b0;
      @(posedge clk);
    end
  endtask
  function automatic logic [8:0] ra(input int grp, input int off);
    return 9'(grp * 64 + off);
  endfunction
  function automatic logic [15:0] div_count(input int events, input int dv);
    return (dv == 31) ? 16'(events) : 16'(events / (2 * (dv + 1)));
  endfunction
  function automatic logic [31:0] in_range(input logic [31:0] x, input int lo, input int hi);
    return {31'h0, x >= 32'(lo) && x <= 32'(hi)};
  endfunction
  initial
  begin
    void'($urandom(27));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (g = 0; g < 4; g++)
    begin
      n = $urandom % 8;
      v = $urandom;
      wr(ra(g, 32 + 4 * n), v);
      rd(ra(g, 32 + 4 * n), c);
      chk("chan_reg", {16'h0, v[15:0]}, c);
      v = $urandom;
      wr(ra(g, 16), v);
      chk("wave", {24'h0, v[15:8] & ~v[7:0]}, {24'h0, wave[g * 8 +: 8]});
    end
    rd(9'h018, c);
    chk("unmapped", 32'h2, {c[29:0], rr});
    wr(9'h018, 32'h1);
    chk("wr_unmapped", 32'h2, {30'h0, wb});
    $display("test registers done");
    wr(ra(2, 4), 32'h0);
    wr(ra(2, 8), 32'h1234);
    rd(ra(2, 8), c);
    chk("held", 32'h0, c);
    wr(ra(2, 0), 32'h7f);
    wr(ra(2, 4), 32'h10);
    wr(ra(2, 8), 32'h8000);
    rd(ra(2, 8), c);
    chk("live", 32'h1, in_range(c, 32'h8000, 32'h8040));
    $display("test access done");
    wr(ra(0, 12), 32'h0);
    wr(ra(0, 16), 32'h100);
    wr(ra(0, 32), 32'h5);
    for (g = 0; g < 2; g++) wr(ra(g, 0), 32'h7f);
    wr(ra(1, 4), 32'h10);
    wr(ra(0, 4), 32'h12);
    // group 1 started early; its first pair reset aligns it with group 0
    repeat (12) @(posedge clk);
    repeat (6)
    begin
      repeat ($urandom % 5) @(posedge clk);
      rd(ra(0, 8), c);
      chk("match", 32'h1, in_range(c, 0, 6));
      rd(ra(1, 8), c);
      chk("partner", 32'h1, in_range(c, 0, 6));
    end
    for (g = 0; g < 2; g++) wr(ra(g, 4), 32'h0);
    $display("test match done");
    n = $urandom % 31;
    wr(ra(3, 0), 32'h1 | (n << 2));
    wr(ra(3, 4), 32'h10);
    rd(ra(3, 8), v);
    pulse(6 * (n + 1));
    rd(ra(3, 8), c);
    chk("event_div", {16'h0, v[15:0] + div_count(6 * (n + 1), n)}, c);
    n = $urandom % 32;
    ev = 4 * (n + 1);
    for (g = 0; g < 2; g++)
    begin
      wr(ra(g, 0), 32'h2 | (n << 2));
      wr(ra(g, 4), 32'h50);
      rd(ra(g, 8), v);
      mbt_quad_model_inst.move(g, ev, 1'b1);
      rd(ra(g, 8), c);
      chk("enc_up", {16'h0, v[15:0] + div_count(ev, n)}, c);
      mbt_quad_model_inst.move(g, ev, 1'b0);
      rd(ra(g, 8), c);
      chk("enc_down", v, c);
    end
    $display("test sources done");
    wr(ra(0, 0), 32'h7f);
    wr(ra(0, 4), 32'h14);
    wr(9'h100, 32'h4);
    mbt_quad_model_inst.pins(1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd(ra(0, 8), c);
    chk("pin_reset", 32'h1, in_range(c, 0, 3));
    mbt_quad_model_inst.pins(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    rd(ra(0, 8), c);
    chk("pin_other", 32'h1, in_range(c, 32, 32'hffff));
    wr(ra(1, 4), 32'h14);
    wr(9'h100, 32'h84);
    rd(ra(0, 8), c);
    chk("pin_pair", 32'h1, in_range(c, 0, 3));
    mbt_quad_model_inst.pins(1'b1, 1'b1);
    wr(9'h100, 32'h0);
    $display("test pins done");
    for (i = 0; i < 3; i++)
    begin
      wr(ra(2, 0), 32'h7f | (i << 7));
      wr(ra(2, 20), 32'h1);
      chk("flag_clear", 32'h0, {31'h0, flag[2]});
      wr(ra(2, 8), (i == 0) ? 32'hffd0 : (i == 1) ? 32'h7fd0 : 32'h3d0);
      repeat (100) @(posedge clk);
      chk("flag_set", 32'h1, {31'h0, flag[2]});
    end
    wr(ra(2, 8), 32'hfff0);
    repeat (40) @(posedge clk);
    rd(ra(2, 8), c);
    chk("wrap", 32'h1, in_range(c, 0, 32'h7f));
    wr(ra(2, 4), 32'h13);
    wr(ra(2, 8), 32'h13f0);
    repeat (40) @(posedge clk);
    rd(ra(2, 8), c);
    chk("bit9_reset", 32'h1, in_range(c, 0, 32'h7f));
    $display("test overflow done");
    wr(ra(1, 0), 32'h7f);
    wr(ra(1, 4), 32'h30);
    wr(ra(1, 8), 32'hffe0);
    repeat (60) @(posedge clk);
    rd(ra(1, 8), c);
    chk("up_down", 32'h1, in_range(c, 32'hff80, 32'hfffd));
    rd(ra(1, 20), c);
    chk("down_flag", 32'h2, c & 32'h2);
    $display("test up_down done");
    complete_run();
  end
endmodule
